//--- asc_pkg.sv
// Constants and types shared by the actuator setpoint configuration block
package asc_pkg;

  // ==========================================================
  // Holding register offsets
  localparam logic [15:0] ASC_OFS_DEADBAND = 16'h9c75;
  localparam logic [15:0] ASC_OFS_CUTOFF = 16'h9c76;
  localparam logic [15:0] ASC_OFS_CLOSE_THR = 16'h9c77;
  localparam logic [15:0] ASC_OFS_OPEN_THR = 16'h9c78;
  localparam logic [15:0] ASC_OFS_CLOSE_CUR = 16'h9c79;
  localparam logic [15:0] ASC_OFS_OPEN_CUR = 16'h9c7a;
  localparam logic [15:0] ASC_OFS_RETRIES = 16'h9c7b;
  localparam logic [15:0] ASC_OFS_SOURCE = 16'h9c83;
  localparam logic [15:0] ASC_OFS_VARIANT = 16'h9c84;

  // ==========================================================
  // Reset values
  localparam logic [15:0] ASC_RST_DEADBAND = 16'h0005;
  localparam logic [15:0] ASC_RST_CUTOFF = 16'h0032;
  localparam logic [15:0] ASC_RST_CLOSE_THR = 16'h0190;
  localparam logic [15:0] ASC_RST_OPEN_THR = 16'h01f4;
  localparam logic [15:0] ASC_RST_CLOSE_CUR = 16'h0028;
  localparam logic [15:0] ASC_RST_OPEN_CUR = 16'h00c8;
  localparam logic [15:0] ASC_RST_RETRIES = 16'h0002;
  localparam logic [15:0] ASC_RST_SOURCE = 16'h0000;
  localparam logic [15:0] ASC_RST_VARIANT = 16'h0001;

  // ==========================================================
  // Accepted value ranges
  localparam logic [15:0] ASC_MIN_ZERO = 16'h0000;
  localparam logic [15:0] ASC_MIN_ONE = 16'h0001;
  localparam logic [15:0] ASC_MAX_DEADBAND = 16'h00fa;
  localparam logic [15:0] ASC_MAX_CUTOFF = 16'h03e7;
  localparam logic [15:0] ASC_MAX_CLOSE_THR = 16'h03e7;
  localparam logic [15:0] ASC_MAX_OPEN_THR = 16'h03e8;
  localparam logic [15:0] ASC_MIN_CUR = 16'h001f;
  localparam logic [15:0] ASC_MAX_CUR = 16'h00dc;
  localparam logic [15:0] ASC_MAX_RETRIES = 16'h0004;
  localparam logic [15:0] ASC_MAX_SOURCE = 16'h0005;
  localparam logic [15:0] ASC_MAX_VARIANT = 16'h000a;

  // ==========================================================
  // Travel positions in tenths of a percent
  localparam logic [15:0] ASC_POS_CLOSED = 16'h0000;
  localparam logic [15:0] ASC_POS_OPEN = 16'h03e8;

  // ==========================================================
  // Command sources and motion states
  typedef enum logic [2:0] {
    ASC_SRC_DUAL_CONTACT = 3'b000,
    ASC_SRC_SINGLE_CONTACT = 3'b001,
    ASC_SRC_LINK_ONOFF = 3'b010,
    ASC_SRC_LINK_POSITION = 3'b011,
    ASC_SRC_LOOP_POSITION = 3'b100,
    ASC_SRC_LOOP_LEVEL = 3'b101
  } asc_source_type;

  typedef enum logic [1:0] {
    ASC_ST_IDLE = 2'b00,
    ASC_ST_MOVE = 2'b01
  } asc_motion_type;

endpackage

//--- asc_cfg_reg.sv
// One range-checked holding register
`timescale 1ns/1ps
module asc_cfg_reg
  import asc_pkg::*;
#(
  parameter logic [15:0] RST_VAL = 16'h0000,
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hffff
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic in_range,
  output logic [15:0] value
);

  // ==========================================================
  // Storage
  logic [15:0] value_reg;
  logic [15:0] value_next;

  assign in_range = (wr_data >= LO) && (wr_data <= HI);
  assign value = value_reg;

  always_comb begin
    value_next = value_reg;
    // Out of range writes leave the old value in place
    if (wr_en && in_range) begin
      value_next = wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      value_reg <= RST_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

endmodule

//--- asc_span_check.sv
// Deadband distance compare between two positions
`timescale 1ns/1ps
module asc_span_check (
  input wire logic [15:0] pos_a,
  input wire logic [15:0] pos_b,
  input wire logic [15:0] band,
  output logic outside
);

  // ==========================================================
  // Absolute difference
  logic [15:0] diff;

  assign diff = (pos_a >= pos_b) ? pos_a - pos_b : pos_b - pos_a;
  // A zero band still needs some change, else moves would repeat
  assign outside = (diff >= band) && (diff != 16'h0000);

endmodule

//--- asc_top.sv
// Setpoint shaping, motion gating and holding registers of the actuator
// Function
// - Start a move only when command differs from last end by deadband.
// - Positioning command below low travel cutoff drives valve closed.
// - Loop on/off mode closes valve at or below close threshold.
// - Loop on/off mode opens valve when command reaches open threshold.
// - Closed position loop current is reported read-only, default 40.
// - Open position loop current is reported read-only, default 200.
// - On obstruction retry up to configured count while command holds.
// - Control source code selects contact, link or loop command input.
`timescale 1ns/1ps
module asc_top
  import asc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err,
  input wire logic contact_open_n_pin,
  input wire logic contact_close_n_pin,
  input wire logic [15:0] link_cmd,
  input wire logic [15:0] loop_cmd,
  input wire logic loop_onoff_en,
  input wire logic cal_load,
  input wire logic [15:0] cal_close_ma,
  input wire logic [15:0] cal_open_ma,
  input wire logic [15:0] pos_fb,
  input wire logic move_done,
  input wire logic move_obstructed,
  output logic move_start,
  output logic [15:0] move_target,
  output logic move_busy,
  output logic obstruct_fault,
  output logic [15:0] end_position,
  output logic [2:0] command_source,
  output logic [3:0] valve_variant,
  output logic valve_onoff_open
);

  // ==========================================================
  // Holding registers
  logic [15:0] deadband;
  logic [15:0] cutoff;
  logic [15:0] close_thr;
  logic [15:0] open_thr;
  logic [15:0] close_cur;
  logic [15:0] open_cur;
  logic [15:0] retries_cfg;
  logic [15:0] source_cfg;
  logic [15:0] variant_cfg;
  logic ok_deadband;
  logic ok_cutoff;
  logic ok_close_thr;
  logic ok_open_thr;
  logic ok_retries;
  logic ok_source;
  logic ok_variant;
  logic ok_close_cur;
  logic ok_open_cur;
  logic hit_deadband;
  logic hit_cutoff;
  logic hit_close_thr;
  logic hit_open_thr;
  logic hit_close_cur;
  logic hit_open_cur;
  logic hit_retries;
  logic hit_source;
  logic hit_variant;

  assign hit_deadband = reg_addr == ASC_OFS_DEADBAND;
  assign hit_cutoff = reg_addr == ASC_OFS_CUTOFF;
  assign hit_close_thr = reg_addr == ASC_OFS_CLOSE_THR;
  assign hit_open_thr = reg_addr == ASC_OFS_OPEN_THR;
  assign hit_close_cur = reg_addr == ASC_OFS_CLOSE_CUR;
  assign hit_open_cur = reg_addr == ASC_OFS_OPEN_CUR;
  assign hit_retries = reg_addr == ASC_OFS_RETRIES;
  assign hit_source = reg_addr == ASC_OFS_SOURCE;
  assign hit_variant = reg_addr == ASC_OFS_VARIANT;

  asc_cfg_reg #(.RST_VAL(ASC_RST_DEADBAND), .LO(ASC_MIN_ZERO),
    .HI(ASC_MAX_DEADBAND)) u_deadband (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .wr_en(reg_wr && hit_deadband),
    .wr_data(reg_wdata), .in_range(ok_deadband), .value(deadband));
  asc_cfg_reg #(.RST_VAL(ASC_RST_CUTOFF), .LO(ASC_MIN_ZERO),
    .HI(ASC_MAX_CUTOFF)) u_cutoff (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .wr_en(reg_wr && hit_cutoff),
    .wr_data(reg_wdata), .in_range(ok_cutoff), .value(cutoff));
  asc_cfg_reg #(.RST_VAL(ASC_RST_CLOSE_THR), .LO(ASC_MIN_ZERO),
    .HI(ASC_MAX_CLOSE_THR)) u_close_thr (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .wr_en(reg_wr && hit_close_thr),
    .wr_data(reg_wdata), .in_range(ok_close_thr), .value(close_thr));
  asc_cfg_reg #(.RST_VAL(ASC_RST_OPEN_THR), .LO(ASC_MIN_ONE),
    .HI(ASC_MAX_OPEN_THR)) u_open_thr (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .wr_en(reg_wr && hit_open_thr),
    .wr_data(reg_wdata), .in_range(ok_open_thr), .value(open_thr));
  asc_cfg_reg #(.RST_VAL(ASC_RST_RETRIES), .LO(ASC_MIN_ZERO),
    .HI(ASC_MAX_RETRIES)) u_retries (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .wr_en(reg_wr && hit_retries),
    .wr_data(reg_wdata), .in_range(ok_retries), .value(retries_cfg));
  asc_cfg_reg #(.RST_VAL(ASC_RST_SOURCE), .LO(ASC_MIN_ZERO),
    .HI(ASC_MAX_SOURCE)) u_source (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .wr_en(reg_wr && hit_source),
    .wr_data(reg_wdata), .in_range(ok_source), .value(source_cfg));
  asc_cfg_reg #(.RST_VAL(ASC_RST_VARIANT), .LO(ASC_MIN_ONE),
    .HI(ASC_MAX_VARIANT)) u_variant (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .wr_en(reg_wr && hit_variant),
    .wr_data(reg_wdata), .in_range(ok_variant), .value(variant_cfg));
  // Loop current endpoints are loaded by calibration, never by the host
  asc_cfg_reg #(.RST_VAL(ASC_RST_CLOSE_CUR), .LO(ASC_MIN_CUR),
    .HI(ASC_MAX_CUR)) u_close_cur (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .wr_en(cal_load),
    .wr_data(cal_close_ma), .in_range(ok_close_cur), .value(close_cur));
  asc_cfg_reg #(.RST_VAL(ASC_RST_OPEN_CUR), .LO(ASC_MIN_CUR),
    .HI(ASC_MAX_CUR)) u_open_cur (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .wr_en(cal_load),
    .wr_data(cal_open_ma), .in_range(ok_open_cur), .value(open_cur));

  assign command_source = source_cfg[2:0];
  assign valve_variant = variant_cfg[3:0];

  // ==========================================================
  // Register access answer
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  logic err_reg;
  logic err_next;

  always_comb begin
    rdata_next = rdata_reg;
    ack_next = reg_wr || reg_rd;
    err_next = 1'b0;
    if (reg_wr) begin
      case (1'b1)
        hit_deadband: err_next = !ok_deadband;
        hit_cutoff: err_next = !ok_cutoff;
        hit_close_thr: err_next = !ok_close_thr;
        hit_open_thr: err_next = !ok_open_thr;
        hit_retries: err_next = !ok_retries;
        hit_source: err_next = !ok_source;
        hit_variant: err_next = !ok_variant;
        default: err_next = 1'b1;
      endcase
    end else if (reg_rd) begin
      err_next = 1'b0;
      case (1'b1)
        hit_deadband: rdata_next = deadband;
        hit_cutoff: rdata_next = cutoff;
        hit_close_thr: rdata_next = close_thr;
        hit_open_thr: rdata_next = open_thr;
        hit_close_cur: rdata_next = close_cur;
        hit_open_cur: rdata_next = open_cur;
        hit_retries: rdata_next = retries_cfg;
        hit_source: rdata_next = source_cfg;
        hit_variant: rdata_next = variant_cfg;
        default: begin
          rdata_next = 16'h0000;
          err_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 16'h0000;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_ack = ack_reg;
  assign reg_err = err_reg;

  // ==========================================================
  // Contact synchronisers and on/off state
  logic [1:0] open_sync_reg;
  logic [1:0] close_sync_reg;
  logic open_made;
  logic close_made;
  logic onoff_reg;
  logic onoff_next;
  logic loop_onoff;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      open_sync_reg <= 2'b11;
      close_sync_reg <= 2'b11;
    end else begin
      open_sync_reg <= {open_sync_reg[0], contact_open_n_pin};
      close_sync_reg <= {close_sync_reg[0], contact_close_n_pin};
    end
  end

  assign open_made = !open_sync_reg[1];
  assign close_made = !close_sync_reg[1];
  assign loop_onoff = loop_onoff_en &&
    (command_source == ASC_SRC_LOOP_POSITION ||
     command_source == ASC_SRC_LOOP_LEVEL);

  always_comb begin
    onoff_next = onoff_reg;
    if (loop_onoff) begin
      // Between the thresholds the last state holds, as a hysteresis band
      if (loop_cmd <= close_thr) begin
        onoff_next = 1'b0;
      end else if (loop_cmd >= open_thr) begin
        onoff_next = 1'b1;
      end
    end else begin
      case (command_source)
        ASC_SRC_DUAL_CONTACT: begin
          if (open_made && !close_made) begin
            onoff_next = 1'b1;
          end else if (close_made && !open_made) begin
            onoff_next = 1'b0;
          end
        end
        ASC_SRC_SINGLE_CONTACT: onoff_next = open_made;
        ASC_SRC_LINK_ONOFF: onoff_next = link_cmd != ASC_POS_CLOSED;
        default: onoff_next = onoff_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      onoff_reg <= 1'b0;
    end else begin
      onoff_reg <= onoff_next;
    end
  end

  assign valve_onoff_open = onoff_reg;

  // ==========================================================
  // Command target
  logic positioning;
  logic [15:0] raw_cmd;
  logic [15:0] cmd_target;

  assign positioning = !loop_onoff &&
    (command_source == ASC_SRC_LINK_POSITION ||
     command_source == ASC_SRC_LOOP_POSITION ||
     command_source == ASC_SRC_LOOP_LEVEL);
  assign raw_cmd = (command_source == ASC_SRC_LINK_POSITION) ?
    link_cmd : loop_cmd;

  always_comb begin
    cmd_target = onoff_reg ? ASC_POS_OPEN : ASC_POS_CLOSED;
    if (positioning) begin
      if (raw_cmd < cutoff) begin
        cmd_target = ASC_POS_CLOSED;
      end else if (raw_cmd > ASC_POS_OPEN) begin
        cmd_target = ASC_POS_OPEN;
      end else begin
        cmd_target = raw_cmd;
      end
    end
  end

  // ==========================================================
  // Motion gating and obstruction retries
  asc_motion_type state_reg;
  asc_motion_type state_next;
  logic [15:0] target_reg;
  logic [15:0] target_next;
  logic [15:0] end_reg;
  logic [15:0] end_next;
  logic [2:0] left_reg;
  logic [2:0] left_next;
  logic fault_reg;
  logic fault_next;
  logic new_move;
  logic cmd_moved;

  asc_span_check u_span_new (.pos_a(cmd_target), .pos_b(end_reg),
    .band(deadband), .outside(new_move));
  asc_span_check u_span_retry (.pos_a(cmd_target), .pos_b(target_reg),
    .band(deadband), .outside(cmd_moved));

  always_comb begin
    state_next = state_reg;
    target_next = target_reg;
    end_next = end_reg;
    left_next = left_reg;
    fault_next = fault_reg;
    move_start = 1'b0;
    case (state_reg)
      ASC_ST_IDLE: begin
        // After a give-up only a real command change may try again
        if (new_move && !(fault_reg && !cmd_moved)) begin
          move_start = 1'b1;
          target_next = cmd_target;
          left_next = retries_cfg[2:0];
          fault_next = 1'b0;
          state_next = ASC_ST_MOVE;
        end
      end
      ASC_ST_MOVE: begin
        if (move_done) begin
          end_next = pos_fb;
          state_next = ASC_ST_IDLE;
        end else if (move_obstructed) begin
          if (left_reg != 3'b000 && !cmd_moved) begin
            move_start = 1'b1;
            left_next = left_reg - 3'b001;
          end else begin
            end_next = pos_fb;
            fault_next = 1'b1;
            state_next = ASC_ST_IDLE;
          end
        end
      end
      default: state_next = ASC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ASC_ST_IDLE;
      target_reg <= ASC_POS_CLOSED;
      end_reg <= ASC_POS_CLOSED;
      left_reg <= 3'b000;
      fault_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      target_reg <= target_next;
      end_reg <= end_next;
      left_reg <= left_next;
      fault_reg <= fault_next;
    end
  end

  assign move_target = target_reg;
  assign move_busy = state_reg == ASC_ST_MOVE;
  assign obstruct_fault = fault_reg;
  assign end_position = end_reg;

  // ==========================================================
  // Checks
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic [15:0] chk_diff;
  assign chk_diff = (cmd_target >= end_reg) ?
    cmd_target - end_reg : end_reg - cmd_target;

  a_start_deadband: assert property (
    (move_start && !move_busy) |-> (chk_diff >= deadband))
    else $error("move started inside deadband");
  a_idle_holds: assert property (
    (!move_busy && chk_diff < deadband) |=> !move_busy)
    else $error("move begun without deadband change");
  a_cutoff_close: assert property (
    (positioning && raw_cmd < cutoff) |-> cmd_target == ASC_POS_CLOSED)
    else $error("cutoff did not close valve");
  a_onoff_close: assert property (
    (loop_onoff && loop_cmd <= close_thr) |=> !valve_onoff_open)
    else $error("loop on/off did not close");
  a_onoff_open: assert property (
    (loop_onoff && loop_cmd >= open_thr && loop_cmd > close_thr)
    |=> valve_onoff_open ##1 (valve_onoff_open || $past(loop_cmd) < open_thr))
    else $error("loop on/off did not open");
  a_ro_close_cur: assert property (
    (reg_wr && hit_close_cur && !cal_load) |=> reg_err && $stable(close_cur))
    else $error("closed current register was writable");
  a_open_report: assert property (
    (reg_rd && hit_open_cur) |=> reg_ack && reg_rdata == $past(open_cur))
    else $error("open current not reported");
  a_retry_spent: assert property (
    (move_busy && !move_done && move_obstructed && left_reg == 3'b000)
    |=> !move_busy && obstruct_fault)
    else $error("retry beyond configured count");
  a_retry_again: assert property (
    (move_busy && !move_done && move_obstructed && left_reg != 3'b000
     && !cmd_moved) |-> move_start ##1 move_busy)
    else $error("retry not issued");
  a_source_single: assert property (
    (command_source == ASC_SRC_SINGLE_CONTACT && !loop_onoff)
    |=> valve_onoff_open == $past(open_made))
    else $error("single contact not followed");
  a_retry_hold: assert property (
    (!move_busy && obstruct_fault && !cmd_moved) |-> !move_start)
    else $error("move repeated after retries spent");
  a_range_reject: assert property (
    (reg_wr && hit_deadband && reg_wdata > ASC_MAX_DEADBAND)
    |=> reg_err && deadband == $past(deadband))
    else $error("out of range deadband accepted");

endmodule

//--- asc_motor_model.sv
// Behavioural motor and position sensor answering move requests
`timescale 1ns/1ps
module asc_motor_model #(
  parameter int DELAY = 5
) (
  input wire logic clk_sys,
  input wire logic move_start,
  input wire logic [15:0] move_target,
  input wire logic obstruct_en,
  output logic move_done,
  output logic move_obstructed,
  output logic [15:0] pos_fb
);
  // ==========================================================
  // Travel timing
  logic go = 1'b0;
  int cnt = 0;
  initial begin
    move_done = 1'b0;
    move_obstructed = 1'b0;
    pos_fb = 16'h0000;
  end
  // Start is combinational, so it is caught on the sampling edge
  always @(posedge clk_sys) go <= move_start;
  always @(negedge clk_sys) begin
    move_done = 1'b0;
    move_obstructed = 1'b0;
    // Sensor reading only means something at the end pulse
    pos_fb = ~pos_fb;
    if (go) begin
      cnt = DELAY;
    end else if (cnt > 0) begin
      cnt--;
      if (cnt == 0) begin
        move_done = !obstruct_en;
        move_obstructed = obstruct_en;
        // A blocked plug stops half way
        pos_fb = obstruct_en ? move_target >> 1 : move_target;
      end
    end
  end
endmodule

//--- tb.sv
// Self-checking bench of the actuator setpoint configuration block
`timescale 1ns/1ps
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin \
  n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, (g), (x)); end end
module tb;
  import asc_pkg::*;
  typedef struct {logic wr; logic [7:0] lo; logic [15:0] d; logic e;}
    asc_row_type;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0;
  logic sys_rst, reg_wr, reg_rd, reg_ack, reg_err, contact_open_n_pin;
  logic contact_close_n_pin, loop_onoff_en, cal_load, move_done;
  logic move_obstructed, move_start, move_busy, obstruct_fault;
  logic valve_onoff_open, obstruct_en;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, link_cmd, loop_cmd;
  logic [15:0] cal_close_ma, cal_open_ma, pos_fb, move_target, end_position;
  logic [2:0] command_source;
  logic [3:0] valve_variant;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_start = 0;
  int cyc = 0;
  asc_row_type rows[$] = '{
    '{1'b0, 8'h75, ASC_RST_DEADBAND, 1'b0},
    '{1'b0, 8'h76, ASC_RST_CUTOFF, 1'b0},
    '{1'b0, 8'h77, ASC_RST_CLOSE_THR, 1'b0},
    '{1'b0, 8'h78, ASC_RST_OPEN_THR, 1'b0},
    '{1'b0, 8'h79, ASC_RST_CLOSE_CUR, 1'b0},
    '{1'b0, 8'h7a, ASC_RST_OPEN_CUR, 1'b0},
    '{1'b0, 8'h7b, ASC_RST_RETRIES, 1'b0},
    '{1'b0, 8'h83, ASC_RST_SOURCE, 1'b0},
    '{1'b0, 8'h84, ASC_RST_VARIANT, 1'b0},
    '{1'b1, 8'h75, 16'h00fa, 1'b0}, '{1'b1, 8'h75, 16'h00fb, 1'b1},
    '{1'b0, 8'h75, 16'h00fa, 1'b0}, '{1'b1, 8'h75, 16'h000a, 1'b0},
    '{1'b1, 8'h76, 16'h03e8, 1'b1}, '{1'b1, 8'h76, 16'h03e7, 1'b0},
    '{1'b0, 8'h76, 16'h03e7, 1'b0}, '{1'b1, 8'h76, 16'h0032, 1'b0},
    '{1'b1, 8'h78, 16'h03e8, 1'b0}, '{1'b1, 8'h77, 16'h03e7, 1'b0},
    '{1'b1, 8'h77, 16'h03e8, 1'b1}, '{1'b0, 8'h77, 16'h03e7, 1'b0},
    '{1'b1, 8'h77, 16'h0190, 1'b0}, '{1'b1, 8'h78, 16'h0000, 1'b1},
    '{1'b1, 8'h78, 16'h01f4, 1'b0}, '{1'b1, 8'h79, 16'h0030, 1'b1},
    '{1'b1, 8'h7a, 16'h0030, 1'b1}, '{1'b0, 8'h79, 16'h0028, 1'b0},
    '{1'b1, 8'h7b, 16'h0005, 1'b1}, '{1'b1, 8'h7b, 16'h0004, 1'b0},
    '{1'b0, 8'h7b, 16'h0004, 1'b0}, '{1'b1, 8'h7b, 16'h0002, 1'b0},
    '{1'b1, 8'h83, 16'h0006, 1'b1}, '{1'b1, 8'h84, 16'h0000, 1'b1},
    '{1'b1, 8'h84, 16'h000a, 1'b0}, '{1'b0, 8'h80, 16'h0000, 1'b1},
    '{1'b1, 8'h80, 16'h0001, 1'b1}};
  // Source [19:16], open [13], close [12], link [4], expected state [0]
  logic [19:0] oo[7] = '{20'h01000, 20'h02001, 20'h03001, 20'h10000,
    20'h13001, 20'h23011, 20'h23000};
  logic [15:0] lp[4] = '{16'h01c2, 16'h0190, 16'h01f3, 16'h03e8};
  logic lv[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  asc_top asc_top_i (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .reg_ack, .reg_err, .contact_open_n_pin,
    .contact_close_n_pin, .link_cmd, .loop_cmd, .loop_onoff_en, .cal_load,
    .cal_close_ma, .cal_open_ma, .pos_fb, .move_done, .move_obstructed,
    .move_start, .move_target, .move_busy, .obstruct_fault, .end_position,
    .command_source, .valve_variant, .valve_onoff_open);
  asc_motor_model asc_motor_model_i (.clk_sys, .move_start, .move_target,
    .obstruct_en, .move_done, .move_obstructed, .pos_fb);
  // ==========================================================
  // Clock, timeout and helpers
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (move_start === 1'b1) n_start++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [15:0] a,
    input logic [15:0] d);
    @(negedge clk_sys);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    `CHK(reg_ack, 1'b1)
  endtask
  task automatic run(input asc_row_type r);
    bus(r.wr, {8'h9c, r.lo}, r.d);
    `CHK(reg_err, r.e)
    if (!r.wr) `CHK(reg_rdata, r.d)
  endtask
  // Contacts pass a two-stage synchroniser, so allow a few edges
  task automatic settle();
    repeat (4) @(negedge clk_sys);
    for (int k = 0; k < 60 && move_busy !== 1'b0; k++) @(negedge clk_sys);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {sys_rst, reg_wr, reg_rd} = 3'h4;
    {contact_open_n_pin, contact_close_n_pin} = 2'h3;
    {loop_onoff_en, cal_load, obstruct_en} = 3'h0;
    {reg_addr, reg_wdata, link_cmd, loop_cmd} = 64'h0;
    {cal_close_ma, cal_open_ma} = 32'h0;
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    foreach (rows[i]) run(rows[i]);
    `CHK(valve_variant, 4'ha)
    // Positioning over the link, deadband 10
    bus(1'b1, ASC_OFS_SOURCE, 16'h0003);
    link_cmd = 16'd300;
    settle();
    `CHK(command_source, ASC_SRC_LINK_POSITION)
    `CHK(end_position, 16'd300)
    n_start = 0;
    link_cmd = 16'd309;
    settle();
    `CHK(n_start, 0)
    link_cmd = 16'd310;
    settle();
    `CHK(end_position, 16'd310)
    link_cmd = 16'd49;
    settle();
    `CHK(end_position, 16'd0)
    // Obstruction: first try plus two retries, then give up
    obstruct_en = 1'b1;
    n_start = 0;
    link_cmd = 16'd600;
    settle();
    `CHK(n_start, 3)
    `CHK(obstruct_fault, 1'b1)
    `CHK(end_position, 16'd300)
    `CHK(move_target, 16'd600)
    bus(1'b1, ASC_OFS_RETRIES, 16'h0000);
    `CHK(n_start, 3)
    n_start = 0;
    link_cmd = 16'd900;
    settle();
    `CHK(n_start, 1)
    obstruct_en = 1'b0;
    link_cmd = 16'd100;
    settle();
    `CHK(obstruct_fault, 1'b0)
    // Current-loop on/off thresholds 400 and 500
    loop_onoff_en = 1'b1;
    bus(1'b1, ASC_OFS_SOURCE, 16'h0004);
    loop_cmd = 16'd500;
    settle();
    `CHK(valve_onoff_open, 1'b1)
    foreach (lp[i]) begin
      loop_cmd = lp[i];
      settle();
      `CHK(valve_onoff_open, lv[i])
    end
    // Contact and link on/off sources
    foreach (oo[i]) begin
      bus(1'b1, ASC_OFS_SOURCE, {12'h000, oo[i][19:16]});
      {contact_open_n_pin, contact_close_n_pin} = ~oo[i][13:12];
      link_cmd = {15'h0000, oo[i][4]};
      settle();
      `CHK(valve_onoff_open, oo[i][0])
    end
    // Loop positioning and level sources, cutoff still 50
    loop_onoff_en = 1'b0;
    loop_cmd = 16'd700;
    bus(1'b1, ASC_OFS_SOURCE, 16'h0004);
    settle();
    `CHK(end_position, 16'd700)
    bus(1'b1, ASC_OFS_SOURCE, 16'h0005);
    loop_cmd = 16'd20;
    settle();
    `CHK(command_source, ASC_SRC_LOOP_LEVEL)
    `CHK(end_position, 16'd0)
    // Endpoint currents loaded by calibration, bad load ignored
    {cal_close_ma, cal_open_ma, cal_load} = {16'd31, 16'd220, 1'b1};
    @(negedge clk_sys);
    {cal_close_ma, cal_load} = {16'd30, 1'b1};
    @(negedge clk_sys);
    cal_load = 1'b0;
    run('{1'b0, 8'h79, 16'd31, 1'b0});
    run('{1'b0, 8'h7a, 16'd220, 1'b0});
    // Second reset in mid-run
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    `CHK(end_position, 16'h0000)
    run('{1'b0, 8'h7b, ASC_RST_RETRIES, 1'b0});
    stop_test();
  end
endmodule
